// file: design/seg_servo_core.sv
// servo enable qualification and electronic gearing with AHB-Lite registers
//
// Functional notes
// - in position mode, while enabled, master pulses advance the commanded motor position through the gear ratio
// - dual-loop only honoured while position mode is selected
// - dual loop: master to second encoder, second to primary ratios
// - resolver primary uses 65536 counts per revolution for second ratio
// - dual loop: second encoder drives the integral path of compensator
// - run setting, no program: enable input active enables drive
// - run setting with program: input acts as inhibit, same as inhibit setting
// - inhibit setting: input is inhibit only; activation never enables
// - inhibit setting: program or interface enable accepted only with input active
// - enable request with input inactive raises fault 36 instead
// - input drop while enabled disables at once and raises fault 36
// - power-up display shows missing module code or bad data code
// - fault disables drive, logs number, sets fault out, clears ready
// - latched fault clears on disable or re-enable per reset option
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module seg_servo_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // master reference pulses, second encoder
  input wire logic master_step_i,
  input wire logic master_dir_i,
  input wire logic second_step_i,
  input wire logic second_dir_i,
  // enable switch and parameter module
  input wire logic enable_inhibit_input_i,
  input wire logic param_module_present_i,
  input wire logic param_module_valid_i,
  // drive status
  output logic drive_enable_o,
  output logic drive_ready_o,
  output logic run_fault_o,
  output logic [3:0] display_code_o,
  output logic irq_o
);
  import seg_pkg::*;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic ph_wr;
  logic [7:0] ph_addr;
  logic [31:0] ctrl;
  logic [31:0] m2s_num;
  logic [31:0] m2s_den;
  logic [31:0] s2p_num;
  logic [31:0] s2p_den;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [31:0] rdata;
  logic [31:0] cmd_pos;
  logic [31:0] integ;
  logic [7:0] fault_log;
  seg_state_t state;
  seg_state_t next_state;
  logic enabled;
  logic ready;
  logic fault_out;
  logic irq;
  logic [3:0] disp;
  logic power_up_done;
  logic module_missing;
  logic module_bad;
  logic in_prev;

  wire addr_phase = hsel_i & hready_i & htrans_i[1];
  wire wr_go = ph_wr;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  wire wr_ctrl = wr_go & hit(ph_addr, SEG_OFF_CTRL);
  wire wr_cmd = wr_go & hit(ph_addr, SEG_OFF_CMD);
  wire wr_istat = wr_go & hit(ph_addr, SEG_OFF_IRQ_STAT);
  wire wr_imask = wr_go & hit(ph_addr, SEG_OFF_IRQ_MASK);
  wire rd_hit = addr_phase & ~hwrite_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr <= addr_phase & hwrite_i;
      ph_addr <= haddr_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= SEG_RST_CTRL;
      m2s_num <= SEG_RST_RATIO;
      m2s_den <= SEG_RST_RATIO;
      s2p_num <= SEG_RST_RATIO;
      s2p_den <= SEG_RST_RATIO;
      irq_mask <= 3'h0;
    end else if (wr_go) begin
      if (wr_ctrl) ctrl <= hwdata_i;
      if (hit(ph_addr, SEG_OFF_M2S_NUM)) m2s_num <= hwdata_i;
      if (hit(ph_addr, SEG_OFF_M2S_DEN)) m2s_den <= hwdata_i;
      if (hit(ph_addr, SEG_OFF_S2P_NUM)) s2p_num <= hwdata_i;
      if (hit(ph_addr, SEG_OFF_S2P_DEN)) s2p_den <= hwdata_i;
      if (wr_imask) irq_mask <= hwdata_i[2:0];
    end
  end

  wire [1:0] mode = ctrl[SEG_CTRL_MODE_LSB +: 2];
  wire pos_mode = (mode == SEG_MODE_POSITION);
  wire ensw_inhibit = ctrl[SEG_CTRL_ENSW_BIT];
  wire dual = ctrl[SEG_CTRL_DUAL_BIT] & pos_mode;
  wire resolver = ctrl[SEG_CTRL_RESOLVER_BIT];
  wire rst_on_reenable = ctrl[SEG_CTRL_RSTOPT_BIT];
  wire prog_running = ctrl[SEG_CTRL_PROG_BIT];
  wire igain_ok = ctrl[SEG_CTRL_IGAIN_OK_BIT];

  // ----------------------------------------------------------------
  // enable qualification
  // ----------------------------------------------------------------
  wire in_act = enable_inhibit_input_i;
  // run setting without program makes the input a plain enable
  wire as_enable = ~ensw_inhibit & ~prog_running;
  wire in_rise = in_act & ~in_prev;
  wire in_fall = ~in_act & in_prev;
  wire req_en = wr_cmd & hwdata_i[SEG_CMD_ENABLE_BIT];
  wire req_dis = wr_cmd & hwdata_i[SEG_CMD_DISABLE_BIT];
  // inhibit behaviour: software requests only, gated by the input
  wire sw_en_ok = req_en & ~as_enable & in_act;
  wire sw_en_bad = req_en & ~as_enable & ~in_act;
  wire hw_en = as_enable & in_rise;
  wire drop = (state == SEG_ST_ENABLED) & ~in_act;
  wire go_fault = drop | sw_en_bad;
  wire fault_clr_dis = (state == SEG_ST_FAULT) & ~rst_on_reenable &
    (req_dis | (as_enable & in_fall));
  wire fault_clr_en = (state == SEG_ST_FAULT) & rst_on_reenable &
    ((req_en & in_act) | hw_en);

  always_comb begin
    next_state = state;
    case (state)
      SEG_ST_DISABLED: begin
        if (go_fault) next_state = SEG_ST_FAULT;
        else if (hw_en | sw_en_ok) next_state = SEG_ST_ENABLED;
      end
      SEG_ST_ENABLED: begin
        if (go_fault) next_state = SEG_ST_FAULT;
        else if (req_dis) next_state = SEG_ST_DISABLED;
      end
      SEG_ST_FAULT: begin
        if (fault_clr_en) next_state = SEG_ST_ENABLED;
        else if (fault_clr_dis) next_state = SEG_ST_DISABLED;
      end
      default: next_state = SEG_ST_DISABLED;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SEG_ST_DISABLED;
      in_prev <= 1'b0;
      fault_log <= 8'h00;
    end else begin
      state <= next_state;
      in_prev <= in_act;
      if (go_fault && state != SEG_ST_FAULT) fault_log <= SEG_FAULT_ENABLE_INPUT;
    end
  end

  // ----------------------------------------------------------------
  // gearing
  // ----------------------------------------------------------------
  logic m_step;
  logic m_dir;
  logic p_step;
  logic p_dir;
  wire run_gear = (state == SEG_ST_ENABLED) & pos_mode;
  // resolver fixes primary counts per revolution
  wire [31:0] s2p_eff_num = resolver ? SEG_RESOLVER_COUNTS : s2p_num;

  seg_ratio_scaler #(.W(32)) u_master (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .num_i(m2s_num),
    .den_i(m2s_den),
    .clear_i(~run_gear),
    .in_step_i(master_step_i),
    .in_dir_i(master_dir_i),
    .out_step_o(m_step),
    .out_dir_o(m_dir)
  );

  seg_ratio_scaler #(.W(32)) u_second (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .num_i(s2p_eff_num),
    .den_i(s2p_den),
    .clear_i(~(run_gear & dual)),
    .in_step_i(m_step),
    .in_dir_i(m_dir),
    .out_step_o(p_step),
    .out_dir_o(p_dir)
  );

  // single loop takes motor counts straight; dual loop chains both ratios
  wire pos_step = dual ? p_step : m_step;
  wire pos_dir = dual ? p_dir : m_dir;
  // integral path sees second-encoder error only when gains are set
  wire int_on = dual & igain_ok & run_gear;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_pos <= 32'h0000_0000;
      integ <= 32'h0000_0000;
    end else begin
      if (run_gear && pos_step) cmd_pos <= pos_dir ? cmd_pos - 32'h1 : cmd_pos + 32'h1;
      if (!int_on) integ <= 32'h0000_0000;
      else if (m_step && !(second_step_i)) integ <= m_dir ? integ - 32'h1 : integ + 32'h1;
      else if (second_step_i && !m_step) integ <= second_dir_i ? integ + 32'h1 : integ - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // power-up display
  // ----------------------------------------------------------------
  // module straps are caught one cycle after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_up_done <= 1'b0;
      module_missing <= 1'b0;
      module_bad <= 1'b0;
    end else if (!power_up_done) begin
      power_up_done <= 1'b1;
      module_missing <= ~param_module_present_i;
      module_bad <= param_module_present_i & ~param_module_valid_i;
    end
  end

  wire [3:0] next_disp = module_missing ? SEG_MODULE_MISSING_CODE :
    module_bad ? SEG_MODULE_DATA_BAD_CODE :
    (next_state == SEG_ST_FAULT) ? SEG_DISPLAY_FAULT_CODE : SEG_DISPLAY_READY_CODE;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  wire [2:0] ev;
  assign ev[SEG_IRQ_FAULT_BIT] = (next_state == SEG_ST_FAULT) & (state != SEG_ST_FAULT);
  assign ev[SEG_IRQ_ENABLED_BIT] = (next_state == SEG_ST_ENABLED) & (state != SEG_ST_ENABLED);
  assign ev[SEG_IRQ_DISABLED_BIT] = (next_state == SEG_ST_DISABLED) & (state == SEG_ST_ENABLED);
  wire [2:0] clr = wr_istat ? hwdata_i[2:0] : 3'h0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev; // set wins over clear
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  wire [31:0] status_word = {24'h0, 1'b0, module_bad, module_missing, fault_out,
    ready, enabled, state};
  wire [7:0] ra = haddr_i[7:0];
  wire [31:0] next_rdata =
    hit(ra, SEG_OFF_CTRL) ? ctrl :
    hit(ra, SEG_OFF_M2S_NUM) ? m2s_num :
    hit(ra, SEG_OFF_M2S_DEN) ? m2s_den :
    hit(ra, SEG_OFF_S2P_NUM) ? s2p_num :
    hit(ra, SEG_OFF_S2P_DEN) ? s2p_den :
    hit(ra, SEG_OFF_STATUS) ? status_word :
    hit(ra, SEG_OFF_IRQ_STAT) ? {29'h0, irq_stat} :
    hit(ra, SEG_OFF_IRQ_MASK) ? {29'h0, irq_mask} :
    hit(ra, SEG_OFF_POS) ? cmd_pos :
    hit(ra, SEG_OFF_INTEG) ? integ :
    hit(ra, SEG_OFF_FAULT) ? {24'h0, fault_log} : 32'h0000_0000;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h0000_0000;
      enabled <= 1'b0;
      ready <= 1'b0;
      fault_out <= 1'b0;
      disp <= SEG_DISPLAY_READY_CODE;
      irq <= 1'b0;
    end else begin
      if (rd_hit) rdata <= next_rdata;
      enabled <= (next_state == SEG_ST_ENABLED);
      fault_out <= (next_state == SEG_ST_FAULT);
      ready <= (next_state != SEG_ST_FAULT) & power_up_done;
      disp <= next_disp;
      irq <= |(((irq_stat & ~clr) | ev) & irq_mask);
    end
  end

  assign hrdata_o = rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign drive_enable_o = enabled;
  assign drive_ready_o = ready;
  assign run_fault_o = fault_out;
  assign display_code_o = disp;
  assign irq_o = irq;
endmodule // seg_servo_core

// file: design/seg_pkg.sv
// package: constants and types for the servo enable and gearing block
package seg_pkg;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] SEG_OFF_CTRL = 8'h00;
  localparam logic [7:0] SEG_OFF_M2S_NUM = 8'h04;
  localparam logic [7:0] SEG_OFF_M2S_DEN = 8'h08;
  localparam logic [7:0] SEG_OFF_S2P_NUM = 8'h0C;
  localparam logic [7:0] SEG_OFF_S2P_DEN = 8'h10;
  localparam logic [7:0] SEG_OFF_CMD = 8'h14;
  localparam logic [7:0] SEG_OFF_STATUS = 8'h18;
  localparam logic [7:0] SEG_OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] SEG_OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] SEG_OFF_POS = 8'h24;
  localparam logic [7:0] SEG_OFF_INTEG = 8'h28;
  localparam logic [7:0] SEG_OFF_FAULT = 8'h2C;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int SEG_CTRL_MODE_LSB = 0;
  localparam int SEG_CTRL_ENSW_BIT = 2;
  localparam int SEG_CTRL_DUAL_BIT = 3;
  localparam int SEG_CTRL_RESOLVER_BIT = 4;
  localparam int SEG_CTRL_RSTOPT_BIT = 5;
  localparam int SEG_CTRL_PROG_BIT = 6;
  localparam int SEG_CTRL_IGAIN_OK_BIT = 7;
  localparam logic [1:0] SEG_MODE_TORQUE = 2'h0;
  localparam logic [1:0] SEG_MODE_VELOCITY = 2'h1;
  localparam logic [1:0] SEG_MODE_POSITION = 2'h2;
  // command bits
  localparam int SEG_CMD_ENABLE_BIT = 0;
  localparam int SEG_CMD_DISABLE_BIT = 1;
  // irq bits
  localparam int SEG_IRQ_FAULT_BIT = 0;
  localparam int SEG_IRQ_ENABLED_BIT = 1;
  localparam int SEG_IRQ_DISABLED_BIT = 2;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEG_FAULT_ENABLE_INPUT = 8'h24;
  localparam logic [31:0] SEG_RESOLVER_COUNTS = 32'h0001_0000;
  localparam logic [31:0] SEG_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] SEG_RST_RATIO = 32'h0000_0001;
  localparam logic [3:0] SEG_MODULE_MISSING_CODE = 4'h1;
  localparam logic [3:0] SEG_MODULE_DATA_BAD_CODE = 4'h2;
  localparam logic [3:0] SEG_DISPLAY_READY_CODE = 4'h0;
  localparam logic [3:0] SEG_DISPLAY_FAULT_CODE = 4'h3;
  typedef enum logic [1:0] {SEG_ST_DISABLED, SEG_ST_ENABLED, SEG_ST_FAULT} seg_state_t;
endpackage

// file: design/seg_ratio_scaler.sv
// ratio scaler: rational pulse multiplier with remainder carried forward
`timescale 1ns/1ps
module seg_ratio_scaler #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // ratio
  input wire logic [W-1:0] num_i,
  input wire logic [W-1:0] den_i,
  input wire logic clear_i,
  // pulses
  input wire logic in_step_i,
  input wire logic in_dir_i,
  output logic out_step_o,
  output logic out_dir_o
);
  logic [W:0] acc;
  logic out_step;
  logic out_dir;
  // accumulate num per input pulse; one output per den; remainder stays
  wire [W:0] sum = acc + {1'b0, num_i};
  wire [W:0] den_x = {1'b0, (den_i == '0) ? {{(W-1){1'b0}}, 1'b1} : den_i};
  wire over = (sum >= den_x);
  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= '0;
      out_step <= 1'b0;
      out_dir <= 1'b0;
    end else if (clear_i) begin
      acc <= '0;
      out_step <= 1'b0;
    end else if (in_step_i) begin
      acc <= over ? sum - den_x : sum;
      out_step <= over;
      out_dir <= in_dir_i;
    end else if (acc >= den_x) begin
      // ratio above one: drain the leftover one output per cycle
      acc <= acc - den_x;
      out_step <= 1'b1;
    end else begin
      out_step <= 1'b0;
    end
  end
  assign out_step_o = out_step;
  assign out_dir_o = out_dir;
endmodule // seg_ratio_scaler

// file: verif/seg_servo_core_sva.sv
// checker: port-level assertions for the servo enable and gearing core
`timescale 1ns/1ps
module seg_servo_core_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // enable and status
  input wire logic enable_inhibit_input_i,
  input wire logic drive_enable_o,
  input wire logic drive_ready_o,
  input wire logic run_fault_o,
  input wire logic [3:0] display_code_o
);
  import seg_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // offsets past the fault log up to 0xFF are unmapped; the core decodes haddr_i[7:0] only
  wire logic rd_unmapped = hsel_i && hready_i && htrans_i[1] && !hwrite_i
    && (haddr_i > 32'h0000_002C);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bus_always_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or answered with error");
  a_unmapped_reads_zero: assert property (rd_unmapped |=> hrdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_fault_no_enable: assert property (run_fault_o |-> !drive_enable_o)
    else $error("drive enabled while in fault");
  a_fault_not_ready: assert property (run_fault_o |-> !drive_ready_o)
    else $error("ready shown while in fault");
  a_fault_display: assert property (run_fault_o |-> display_code_o == SEG_DISPLAY_FAULT_CODE)
    else $error("display does not show fault");
  a_input_drop_faults: assert property (drive_enable_o && !enable_inhibit_input_i
    |-> ##[1:2] (run_fault_o && !drive_enable_o))
    else $error("input drop did not fault the drive");
  a_enable_needs_input: assert property ($rose(drive_enable_o)
    |-> $past(enable_inhibit_input_i) || $past(enable_inhibit_input_i, 2))
    else $error("drive enabled without active input");
  a_low_stays_off: assert property (!enable_inhibit_input_i
    && !$past(enable_inhibit_input_i) && !drive_enable_o |=> !drive_enable_o)
    else $error("drive enabled while input inactive");
endmodule // seg_servo_core_sva

bind seg_servo_core seg_servo_core_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .enable_inhibit_input_i(enable_inhibit_input_i), .drive_enable_o(drive_enable_o),
  .drive_ready_o(drive_ready_o), .run_fault_o(run_fault_o), .display_code_o(display_code_o));

// file: verif/seg_partner.sv
// partner: master pulse source, second encoder and enable switch
`timescale 1ns/1ps
module seg_partner (
  // clock
  input wire logic clk_sys_i,
  // pulse sources and switch
  output logic master_step_o,
  output logic master_dir_o,
  output logic second_step_o,
  output logic second_dir_o,
  output logic switch_o
);
  initial begin
    master_step_o = 1'b0;
    master_dir_o = 1'b0;
    second_step_o = 1'b0;
    second_dir_o = 1'b0;
    switch_o = 1'b0;
  end
  // one-cycle pulses; the gap lets a 3:1 ratio drain between counts
  task automatic pulses(input int n, input logic dir, input logic sec);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      master_step_o <= !sec;
      second_step_o <= sec;
      master_dir_o <= dir;
      second_dir_o <= dir;
      @(posedge clk_sys_i);
      master_step_o <= 1'b0;
      second_step_o <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
    end
  endtask
  task automatic sw(input logic v);
    @(posedge clk_sys_i);
    switch_o <= v;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule // seg_partner

// file: verif/seg_servo_core_tb.sv
// testbench: bus tasks, scenarios and verdict for the servo core
`timescale 1ns/1ps
module seg_servo_core_tb;
  import seg_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [2:0] hsize_i = 3'h0;
  logic present = 1'b1;
  logic valid = 1'b1;
  logic [31:0] hrdata_o, rd, p0;
  logic hreadyout_o, hresp_o, m_step, m_dir, s_step, s_dir, sw_lvl;
  logic drive_enable_o, drive_ready_o, run_fault_o, irq_o;
  logic [3:0] display_code_o;
  int fail_count = 0;
  int check_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  seg_partner far (.clk_sys_i(clk_sys_i), .master_step_o(m_step), .master_dir_o(m_dir),
    .second_step_o(s_step), .second_dir_o(s_dir), .switch_o(sw_lvl));
  seg_servo_core DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .master_step_i(m_step),
    .master_dir_i(m_dir), .second_step_i(s_step), .second_dir_i(s_dir),
    .enable_inhibit_input_i(sw_lvl), .param_module_present_i(present),
    .param_module_valid_i(valid), .drive_enable_o(drive_enable_o),
    .drive_ready_o(drive_ready_o), .run_fault_o(run_fault_o),
    .display_code_o(display_code_o), .irq_o(irq_o));
  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // called just after a rising edge; no wait-state count is assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    hsize_i <= 3'h2;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    rd = hrdata_o;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  // bounded wait for the enable or fault output to reach a level
  task automatic wait_out(input bit flt, input logic v);
    for (int i = 0; i < 8 && (flt ? run_fault_o : drive_enable_o) !== v; i++) begin
      @(posedge clk_sys_i);
    end
    check(flt ? "fault" : "enable", flt ? run_fault_o : drive_enable_o, v);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    rd_chk("ctrl", SEG_OFF_CTRL, SEG_RST_CTRL);
    for (int i = 0; i < 4; i++) begin
      rd_chk("ratio", SEG_OFF_M2S_NUM + 8'(4 * i), SEG_RST_RATIO);
    end
    bus(1'b1, SEG_OFF_STATUS, 32'hFF);
    rd_chk("status", SEG_OFF_STATUS, 32'h8);
    bus(1'b1, 8'h30, 32'h5A);
    rd_chk("unmapped", 8'h30, 32'h0);
    check("display", display_code_o, SEG_DISPLAY_READY_CODE);
  endtask
  task automatic sc_run();
    bus(1'b1, SEG_OFF_CTRL, 32'h2);
    bus(1'b1, SEG_OFF_IRQ_MASK, 32'h1);
    far.sw(1'b1);
    wait_out(1'b0, 1'b1);
    check("irq masked", irq_o, 1'b0);
    far.sw(1'b0);
    wait_out(1'b1, 1'b1);
    check("ready", drive_ready_o, 1'b0);
    rd_chk("fault log", SEG_OFF_FAULT, 32'(SEG_FAULT_ENABLE_INPUT));
    rd_chk("status", SEG_OFF_STATUS, 32'h12);
    check("irq", irq_o, 1'b1);
    bus(1'b1, SEG_OFF_IRQ_STAT, 32'h1);
    // irq flop updates on the edge that ends the write
    @(posedge clk_sys_i);
    check("irq cleared", irq_o, 1'b0);
    bus(1'b1, SEG_OFF_CMD, 32'h2);
    wait_out(1'b1, 1'b0);
  endtask
  task automatic sc_inhibit();
    bus(1'b1, SEG_OFF_CTRL, 32'h26);
    far.sw(1'b1);
    repeat (6) @(posedge clk_sys_i);
    check("enable", drive_enable_o, 1'b0);
    far.sw(1'b0);
    bus(1'b1, SEG_OFF_CMD, 32'h1);
    wait_out(1'b1, 1'b1);
    rd_chk("fault log", SEG_OFF_FAULT, 32'(SEG_FAULT_ENABLE_INPUT));
    far.sw(1'b1);
    bus(1'b1, SEG_OFF_CMD, 32'h1);
    wait_out(1'b1, 1'b0);
    bus(1'b1, SEG_OFF_CMD, 32'h1);
    wait_out(1'b0, 1'b1);
    far.sw(1'b0);
    wait_out(1'b1, 1'b1);
  endtask
  task automatic sc_prog();
    bus(1'b1, SEG_OFF_CTRL, 32'h42);
    bus(1'b1, SEG_OFF_CMD, 32'h2);
    far.sw(1'b1);
    repeat (6) @(posedge clk_sys_i);
    check("enable", drive_enable_o, 1'b0);
    bus(1'b1, SEG_OFF_CMD, 32'h1);
    wait_out(1'b0, 1'b1);
  endtask
  task automatic sc_gear();
    // 1000 master over 4000 motor counts at 4:3 gear gives 1:3
    bus(1'b1, SEG_OFF_M2S_DEN, 32'h3);
    rd_chk("pos", SEG_OFF_POS, 32'h0);
    p0 = rd;
    far.pulses(10, 1'b0, 1'b0);
    rd_chk("pos", SEG_OFF_POS, p0 + 32'h3);
    far.pulses(2, 1'b0, 1'b0);
    rd_chk("pos", SEG_OFF_POS, p0 + 32'h4);
    far.pulses(6, 1'b1, 1'b0);
    rd_chk("pos", SEG_OFF_POS, p0 + 32'h2);
    bus(1'b1, SEG_OFF_M2S_NUM, 32'h3);
    bus(1'b1, SEG_OFF_M2S_DEN, 32'h1);
    far.pulses(2, 1'b0, 1'b0);
    rd_chk("pos", SEG_OFF_POS, p0 + 32'h8);
  endtask
  task automatic sc_dual();
    bus(1'b1, SEG_OFF_CMD, 32'h2);
    bus(1'b1, SEG_OFF_CTRL, 32'h89);
    far.sw(1'b0);
    far.sw(1'b1);
    wait_out(1'b0, 1'b1);
    rd_chk("integ", SEG_OFF_INTEG, 32'h0);
    p0 = rd;
    far.pulses(3, 1'b0, 1'b1);
    rd_chk("integ", SEG_OFF_INTEG, p0);
    bus(1'b1, SEG_OFF_CTRL, 32'h8A);
    bus(1'b1, SEG_OFF_M2S_NUM, 32'h1);
    bus(1'b1, SEG_OFF_M2S_DEN, 32'h2);
    far.pulses(4, 1'b0, 1'b0);
    rd_chk("integ", SEG_OFF_INTEG, p0 + 32'h2);
    far.pulses(1, 1'b0, 1'b1);
    rd_chk("integ", SEG_OFF_INTEG, p0 + 32'h1);
    // resolver primary: 65536 over 32768 gives two motor counts per second count
    bus(1'b1, SEG_OFF_S2P_DEN, 32'h0000_8000);
    bus(1'b1, SEG_OFF_CTRL, 32'h9A);
    bus(1'b0, SEG_OFF_POS, 32'h0);
    p0 = rd;
    far.pulses(2, 1'b0, 1'b0);
    rd_chk("pos", SEG_OFF_POS, p0 + 32'h2);
  endtask
  task automatic sc_module(input logic pres, input logic val, input logic [3:0] code);
    rst_n_i <= 1'b0;
    present <= pres;
    valid <= val;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check("display", display_code_o, code);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    sc_regs();
    sc_run();
    sc_inhibit();
    sc_prog();
    sc_gear();
    sc_dual();
    sc_module(1'b0, 1'b1, SEG_MODULE_MISSING_CODE);
    sc_module(1'b1, 1'b0, SEG_MODULE_DATA_BAD_CODE);
    wrap_up();
  end
endmodule // seg_servo_core_tb
